/* bench/fbtc_filter_bw_ctrl_tb.sv */
// Self-checking bench for the bandwidth tuning control block.
// Assumes the host model drives all serial input pins and the reference clock.
`timescale 1ns/1ps
module fbtc_filter_bw_ctrl_tb
	import fbtc_pkg::*;
;
	logic              clk_in;
	logic              srst_in;
	logic              sen_n;
	logic              sck;
	logic              sdi;
	logic              cal_ref;
	logic [3:0]        sc;
	logic [3:0]        sf;
	logic              sdo;
	logic              sdo_oe_n;
	logic [3:0]        act_c;
	logic [3:0]        act_f;
	logic              busy;
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] exp_q[$];
	event              got_ev;
	int                fail_count = 0;
	int                n_compared = 0;

	fbtc_filter_bw_ctrl uut (.clk_in(clk_in), .srst_in(srst_in),
		.spi_sen_n_in(sen_n), .spi_sck_in(sck), .spi_sdi_in(sdi),
		.cal_reference_clock_in(cal_ref), .stored_coarse_in(sc),
		.stored_fine_in(sf), .spi_sdo_out(sdo), .spi_sdo_oe_n_out(sdo_oe_n),
		.active_coarse_out(act_c), .active_fine_out(act_f),
		.cal_busy_out(busy));
	fbtc_host_model host (.clk_in(clk_in), .sdo_in(sdo), .sen_n_out(sen_n),
		.sck_out(sck), .sdi_out(sdi), .cal_ref_out(cal_ref));

	always #2.5 clk_in = ~clk_in;

	// ==========================================
	// Compare and report
	task automatic compare_word(input logic [DATA_W-1:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic compare_code(input logic [3:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: code %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Oldest note against each read result
	always @(got_ev) begin
		if (exp_q.size() == 0) begin
			fail_count++;
			$display("Error at %0t: read without expectation", $time);
		end else
			compare_word(rd_word, exp_q.pop_front());
	end

	// ==========================================
	// Register access
	task automatic wr(input logic [4:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] rd;
		host.xfer(CHIP_ADDR, a, d, rd);
	endtask

	task automatic read_reg(input logic [4:0] a,
		output logic [DATA_W-1:0] rd);
		host.xfer(CHIP_ADDR, REG_POINTER, {19'h0, a}, rd);
		host.xfer(CHIP_ADDR, REG_POINTER, {19'h0, a}, rd);
	endtask

	task automatic read_expect(input logic [4:0] a,
		input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] rd;
		exp_q.push_back(e);
		read_reg(a, rd);
		rd_word = rd;
		->got_ev;
	endtask

	// Typical coarse corners and fine ratios
	real coarse_typ [9]  = '{5.0, 7.0, 10.0, 14.0, 20.0, 28.0, 40.0,
		50.0, 72.0};
	real fine_typ   [12] = '{0.803, 0.832, 0.862, 0.893, 0.926, 0.959,
		0.994, 1.030, 1.063, 1.097, 1.136, 1.183};

	// Host picks both codes for a wanted corner, then applies them
	task automatic set_corner(input real fw,
		input logic [DATA_W-1:0] meas, input bit cal);
		real        fn, r;
		logic [3:0] c, f;
		fn = cal ? fw * (real'(meas) + 153600.0) / 10370000.0 : fw;
		c = 4'h0;
		for (int i = 1; i < 9; i++)
			if ((fn - coarse_typ[i]) * (fn - coarse_typ[i])
					< (fn - coarse_typ[c]) * (fn - coarse_typ[c]))
				c = 4'(i);
		r = fn / coarse_typ[c];
		f = 4'h0;
		for (int i = 1; i < 12; i++)
			if ((r - fine_typ[i]) * (r - fine_typ[i])
					< (r - fine_typ[f]) * (r - fine_typ[f]))
				f = 4'(i);
		wr(REG_COARSE, 24'(c) << COARSE_LSB);
		wr(REG_FINE, 24'(f));
		wr(REG_CONTROL, 24'h000010);
		compare_code(act_c, c);
		compare_code(act_f, f);
	endtask

	function automatic logic [DATA_W-1:0] in_range(logic [DATA_W-1:0] m);
		return (m >= 24'd2045 && m <= 24'd2051) ? 24'd2048 : m;
	endfunction

	initial begin
		#400000;
		fail_count++;
		$display("Error at %0t: run limit reached", $time);
		report_and_stop();
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [3:0]        c, f, pc, pf, ec;
		logic [DATA_W-1:0] m;
		int                n;
		void'($urandom(32'hc6d97f49));
		clk_in = 1'b0;
		srst_in = 1'b1;
		sc = 4'($urandom_range(8));
		sf = 4'($urandom_range(11));
		pc = RST_CODE;
		pf = RST_CODE;
		repeat (4) @(posedge clk_in);
		srst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		compare_code(act_c, RST_CODE);
		compare_code(act_f, RST_CODE);
		read_expect(REG_CONTROL, RST_WORD);
		// Every listed code, then one random pair
		for (int k = 0; k < 13; k++) begin
			c = (k == 12) ? 4'($urandom_range(8)) : 4'(k % 9);
			f = (k == 12) ? 4'($urandom_range(11)) : 4'(k);
			wr(REG_COARSE, 24'(c) << COARSE_LSB);
			wr(REG_FINE, 24'(f));
			compare_code(act_c, pc);
			compare_code(act_f, pf);
			wr(REG_CONTROL, 24'h000010);
			compare_code(act_c, c);
			compare_code(act_f, f);
			pc = c;
			pf = f;
		end
		host.xfer(3'h3, REG_COARSE, 24'h000200, m);
		read_expect(REG_COARSE, 24'(pc) << COARSE_LSB);
		read_expect(REG_FINE, 24'(pf));
		read_expect(REG_CONTROL, 24'h000000);
		read_expect(5'h1F, 24'h000000);
		wr(REG_STORED, 24'hFFFFFF);
		read_expect(REG_STORED, (24'(sc) << COARSE_LSB) | 24'(sf));
		// Calibration with the reference running
		host.ref_clock(1'b1);
		wr(REG_FINE, 24'h00000B);
		wr(REG_CAL_PERIOD, 24'd20000);
		wr(REG_CONTROL, 24'h000022);
		wr(REG_CAL_START, 24'h000000);
		compare_code({3'h0, busy}, 4'h1);
		read_expect(REG_STATUS, 24'h000010);
		for (n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge clk_in);
		if (n == 5000) begin
			fail_count++;
			$display("Error at %0t: calibration never finished", $time);
		end else begin
			host.ref_clock(1'b0);
			ec = 4'h0;
			for (int j = 0; j < 11; j++)
				if (FINE_BOUND[j] <= 24'd2048) ec++;
			read_reg(REG_MEASURE, m);
			compare_word(in_range(m), 24'd2048);
			read_expect(REG_FINE, 24'(ec));
			read_expect(REG_STATUS, 24'(ec));
			wr(REG_MEASURE, 24'h000000);
			read_reg(REG_MEASURE, m);
			compare_word(in_range(m), 24'd2048);
			compare_code(act_f, pf);
			wr(REG_CONTROL, 24'h000012);
			compare_code(act_f, ec);
			set_corner(13.0, m, 1'b1);
			set_corner(real'($urandom_range(72, 5)), m, 1'b0);
			repeat (2) @(posedge clk_in);
		end
		report_and_stop();
	end
endmodule

/* bench/fbtc_host_model.sv */
// Host model: serial register frames and the calibration reference clock.
// Assumes a 200 MHz clk_in; every serial phase lasts six clk_in cycles.
`timescale 1ns/1ps
module fbtc_host_model
	import fbtc_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic sdo_in,
	output logic      sen_n_out,
	output logic      sck_out,
	output logic      sdi_out,
	output logic      cal_ref_out
);
	logic ref_run;

	// ==========================================
	// Reference clock, 25 MHz, still when idle
	initial begin
		ref_run = 1'b0;
		cal_ref_out = 1'b0;
		sen_n_out = 1'b1;
		sck_out = 1'b0;
		sdi_out = 1'b0;
		#1.3;
		forever begin
			#20;
			cal_ref_out = ref_run & ~cal_ref_out;
		end
	end

	task automatic ref_clock(input logic on);
		ref_run = on;
	endtask

	// ==========================================
	// One frame: data, address, chip bits
	task automatic xfer(input logic [2:0] ca, input logic [4:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd);
		logic [31:0] w;
		w = {d, a, ca};
		rd = '0;
		@(posedge clk_in);
		sen_n_out <= 1'b0;
		sdi_out <= w[31];
		repeat (6) @(posedge clk_in);
		for (int i = 31; i >= 0; i--) begin
			if (i > 7) rd = {rd[DATA_W-2:0], sdo_in};
			sck_out <= 1'b1;
			repeat (6) @(posedge clk_in);
			sck_out <= 1'b0;
			sdi_out <= (i > 0) ? w[(i > 0) ? i - 1 : 0] : ~w[0];
			repeat (6) @(posedge clk_in);
		end
		sen_n_out <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask
endmodule

/* pkg/fbtc_pkg.sv */
// Constants, types and register map for the filter bandwidth tuning block.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
package fbtc_pkg;

	// ==========================================================
	// Widths and serial framing
	localparam int          DATA_W     = 24;
	localparam int          ADDR_W     = 5;
	localparam logic [5:0]  FRAME_BITS = 6'h20;
	localparam logic [2:0]  CHIP_ADDR  = 3'h5;

	// ==========================================================
	// Register offsets
	localparam logic [4:0] REG_POINTER    = 5'h00;
	localparam logic [4:0] REG_CONTROL    = 5'h01;
	localparam logic [4:0] REG_COARSE     = 5'h02;
	localparam logic [4:0] REG_FINE       = 5'h03;
	localparam logic [4:0] REG_CAL_START  = 5'h04;
	localparam logic [4:0] REG_CAL_PERIOD = 5'h05;
	localparam logic [4:0] REG_CAL_TRIM   = 5'h06;
	localparam logic [4:0] REG_STATUS     = 5'h08;
	localparam logic [4:0] REG_MEASURE    = 5'h09;
	localparam logic [4:0] REG_STORED     = 5'h0A;

	// ==========================================================
	// Field positions
	localparam int CTL_CAL_EN_BIT  = 1;
	localparam int CTL_APPLY_BIT   = 4;
	localparam int CTL_DOUBLER_BIT = 5;
	localparam int COARSE_LSB      = 6;
	localparam int COARSE_MSB      = 9;
	localparam int FINE_LSB        = 0;
	localparam int FINE_MSB        = 3;
	localparam int STAT_BUSY_BIT   = 4;
	localparam int PERIOD_MSB      = 14;
	localparam int TRIM_MSB        = 8;

	// ==========================================================
	// Reset values and counts
	localparam logic [23:0] RST_WORD      = 24'h000000;
	localparam logic [3:0]  RST_CODE      = 4'h0;
	localparam logic [23:0] CAL_REF_EDGES = 24'h000100;
	localparam logic [23:0] CAL_CNT_MAX   = 24'hFFFFFF;

	// Measurement thresholds between adjacent fine codes
	localparam logic [10:0][23:0] FINE_BOUND = {
		24'hB46A86, 24'hAE3EB8, 24'hA83B6C, 24'hA37C30,
		24'h9DC9E8, 24'h9817A0, 24'h92DEDE, 24'h8D7D9A,
		24'h8895DC, 24'h83859C, 24'h7F1764};

	// ==========================================================
	// Types
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fbtc_frame_type;

	typedef enum logic [1:0] {
		CAL_IDLE    = 2'b00,
		CAL_ARM     = 2'b01,
		CAL_MEASURE = 2'b10,
		CAL_DONE    = 2'b11
	} fbtc_cal_state_type;

endpackage

/* rtl/fbtc_filter_bw_ctrl.sv */
// Bandwidth tuning control: register file, apply logic, RC calibration.
// Assumes a host on the serial port and a reference clock during calibration.
//
// Function
// - Coarse corner choice is bits 9:6 of the coarse bandwidth register.
// - Fine trim is bits 3:0 of the fine bandwidth register.
// - New codes take effect only when control bit 4 is written one.
// - Coarse codes 0 to 8 select 5 to 72 MHz corners; others undefined.
// - Fine codes 0 to 11 scale the corner from 0.803 to 1.183.
// - Calibration overwrites the fine trim field itself in automatic mode; the code writes the previous run's cal_fine there, not this run's fine_pick.
// - Calibration measurement reads as 24-bit read-only value, bits 23:0.
// - Stored factory codes are readable through a dedicated register.
// - Status bit 4 is one while calibration runs, zero when finished.
// - Writing zero to calibration start begins calibration once set up.
`timescale 1ns/1ps
module fbtc_filter_bw_ctrl
	import fbtc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	input  wire logic       spi_sen_n_in,
	input  wire logic       spi_sck_in,
	input  wire logic       spi_sdi_in,
	input  wire logic       cal_reference_clock_in,
	input  wire logic [3:0] stored_coarse_in,
	input  wire logic [3:0] stored_fine_in,
	output logic            spi_sdo_out,
	output logic            spi_sdo_oe_n_out,
	output logic [3:0]      active_coarse_out,
	output logic [3:0]      active_fine_out,
	output logic            cal_busy_out
);

	// ==========================================================
	// Serial port
	fbtc_frame_type    frame;
	logic              frame_valid;
	logic [DATA_W-1:0] read_word;

	fbtc_spi_port u_port (
		.clk_in          (clk_in),
		.srst_in         (srst_in),
		.spi_sen_n_in    (spi_sen_n_in),
		.spi_sck_in      (spi_sck_in),
		.spi_sdi_in      (spi_sdi_in),
		.read_word_in    (read_word),
		.frame_out       (frame),
		.frame_valid_out (frame_valid),
		.sdo_out         (spi_sdo_out),
		.sdo_oe_n_out    (spi_sdo_oe_n_out)
	);

	logic wr_pointer, wr_control, wr_coarse, wr_fine;
	logic wr_start, wr_period, wr_trim;
	assign wr_pointer = frame_valid && frame.addr == REG_POINTER;
	assign wr_control = frame_valid && frame.addr == REG_CONTROL;
	assign wr_coarse  = frame_valid && frame.addr == REG_COARSE;
	assign wr_fine    = frame_valid && frame.addr == REG_FINE;
	assign wr_start   = frame_valid && frame.addr == REG_CAL_START;
	assign wr_period  = frame_valid && frame.addr == REG_CAL_PERIOD;
	assign wr_trim    = frame_valid && frame.addr == REG_CAL_TRIM;

	// ==========================================================
	// Register file and adopted codes
	logic [4:0]          pointer, next_pointer;
	logic [DATA_W-1:0]   control, next_control;
	logic [DATA_W-1:0]   coarse_reg, next_coarse_reg;
	logic [DATA_W-1:0]   fine_reg, next_fine_reg;
	logic [PERIOD_MSB:0] period, next_period;
	logic [TRIM_MSB:0]   trim, next_trim;
	logic [3:0]          next_active_coarse, next_active_fine;
	logic                cal_done;
	logic [3:0]          cal_fine;
	logic [23:0]         measure;

	always_comb begin
		next_pointer       = pointer;
		next_control       = control;
		next_coarse_reg    = coarse_reg;
		next_fine_reg      = fine_reg;
		next_period        = period;
		next_trim          = trim;
		next_active_coarse = active_coarse_out;
		next_active_fine   = active_fine_out;
		if (wr_pointer) begin
			next_pointer = frame.data[4:0];
		end
		if (wr_control) begin
			next_control = frame.data;
			next_control[CTL_APPLY_BIT] = 1'b0;
		end
		if (wr_coarse) begin
			next_coarse_reg = frame.data;
		end
		if (wr_fine) begin
			next_fine_reg = frame.data;
		end
		if (cal_done) begin
			next_fine_reg[FINE_MSB:FINE_LSB] = cal_fine;
		end
		if (wr_period) begin
			next_period = frame.data[PERIOD_MSB:0];
		end
		if (wr_trim) begin
			next_trim = frame.data[TRIM_MSB:0];
		end
		if (wr_control && frame.data[CTL_APPLY_BIT]) begin
			next_active_coarse = coarse_reg[COARSE_MSB:COARSE_LSB];
			next_active_fine   = fine_reg[FINE_MSB:FINE_LSB];
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pointer           <= 5'h00;
			control           <= RST_WORD;
			coarse_reg        <= RST_WORD;
			fine_reg          <= RST_WORD;
			period            <= 15'h0000;
			trim              <= 9'h000;
			active_coarse_out <= RST_CODE;
			active_fine_out   <= RST_CODE;
		end else begin
			pointer           <= next_pointer;
			control           <= next_control;
			coarse_reg        <= next_coarse_reg;
			fine_reg          <= next_fine_reg;
			period            <= next_period;
			trim              <= next_trim;
			active_coarse_out <= next_active_coarse;
			active_fine_out   <= next_active_fine;
		end
	end

	// ==========================================================
	// Read mux
	always_comb begin
		read_word = RST_WORD;
		case (pointer)
			REG_POINTER:    read_word[4:0] = pointer;
			REG_CONTROL:    read_word = control;
			REG_COARSE:     read_word = coarse_reg;
			REG_FINE:       read_word = fine_reg;
			REG_CAL_PERIOD: read_word[PERIOD_MSB:0] = period;
			REG_CAL_TRIM:   read_word[TRIM_MSB:0] = trim;
			REG_STATUS: begin
				read_word[STAT_BUSY_BIT] = cal_busy_out;
				read_word[FINE_MSB:FINE_LSB] = cal_fine;
			end
			REG_MEASURE:    read_word = measure;
			REG_STORED: begin
				read_word[COARSE_MSB:COARSE_LSB] = stored_coarse_in;
				read_word[FINE_MSB:FINE_LSB] = stored_fine_in;
			end
			default:        read_word = RST_WORD;
		endcase
	end

	// ==========================================================
	// Reference clock sampling
	logic ref_meta, ref_sync, ref_prev;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ref_meta <= 1'b0;
			ref_sync <= 1'b0;
			ref_prev <= 1'b0;
		end else begin
			ref_meta <= cal_reference_clock_in;
			ref_sync <= ref_meta;
			ref_prev <= ref_sync;
		end
	end
	logic ref_rise;
	assign ref_rise = ref_sync & ~ref_prev;

	// ==========================================================
	// Calibration engine
	fbtc_cal_state_type state, next_state;
	logic [23:0]        cyc_cnt, next_cyc_cnt;
	logic [23:0]        edge_cnt, next_edge_cnt;
	logic [23:0]        next_measure;
	logic [3:0]         next_cal_fine;
	logic               next_busy;
	logic               start_ok;
	logic [3:0]         fine_pick;

	assign start_ok = wr_start && frame.data == RST_WORD
		&& control[CTL_CAL_EN_BIT] && period != 15'h0000;
	assign cal_done = state == CAL_DONE;

	always_comb begin
		fine_pick = 4'h0;
		for (int i = 0; i < 11; i++) begin
			if (measure >= FINE_BOUND[i]) begin
				fine_pick = 4'(i + 1);
			end
		end
	end

	always_comb begin
		next_state    = state;
		next_cyc_cnt  = cyc_cnt;
		next_edge_cnt = edge_cnt;
		next_measure  = measure;
		next_cal_fine = cal_fine;
		next_busy     = cal_busy_out;
		case (state)
			CAL_IDLE: begin
				if (start_ok) begin
					next_state = CAL_ARM;
					next_busy  = 1'b1;
					next_cyc_cnt  = 24'h000000;
					next_edge_cnt = 24'h000000;
				end
			end
			CAL_ARM: begin
				next_cyc_cnt = cyc_cnt + 24'h000001;
				if (ref_rise) begin
					next_state   = CAL_MEASURE;
					next_cyc_cnt = 24'h000000;
				end else if (cyc_cnt == CAL_CNT_MAX) begin
					next_state = CAL_DONE;
				end
			end
			CAL_MEASURE: begin
				next_cyc_cnt = cyc_cnt + 24'h000001;
				if (ref_rise) begin
					next_edge_cnt = edge_cnt + 24'h000001;
				end
				if ((ref_rise && next_edge_cnt == CAL_REF_EDGES)
						|| cyc_cnt == CAL_CNT_MAX) begin
					next_measure = next_cyc_cnt;
					next_state   = CAL_DONE;
				end
			end
			CAL_DONE: begin
				next_cal_fine = fine_pick;
				next_state    = CAL_IDLE;
				next_busy     = 1'b0;
			end
			default: begin
				next_state = CAL_IDLE;
				next_busy  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state        <= CAL_IDLE;
			cyc_cnt      <= 24'h000000;
			edge_cnt     <= 24'h000000;
			measure      <= RST_WORD;
			cal_fine     <= RST_CODE;
			cal_busy_out <= 1'b0;
		end else begin
			state        <= next_state;
			cyc_cnt      <= next_cyc_cnt;
			edge_cnt     <= next_edge_cnt;
			measure      <= next_measure;
			cal_fine     <= next_cal_fine;
			cal_busy_out <= next_busy;
		end
	end

	// ==========================================================
	// Assertions
	a_apply_adopt: assert property (@(posedge clk_in) disable iff (srst_in)
		wr_control && frame.data[CTL_APPLY_BIT]
		|=> active_coarse_out == $past(coarse_reg[COARSE_MSB:COARSE_LSB])
		&& active_fine_out == $past(fine_reg[FINE_MSB:FINE_LSB]))
		else $error("apply did not adopt codes");

	a_hold_codes: assert property (@(posedge clk_in) disable iff (srst_in)
		!(wr_control && frame.data[CTL_APPLY_BIT])
		|=> $stable(active_coarse_out) && $stable(active_fine_out))
		else $error("active codes changed without apply");

	a_coarse_field: assert property (@(posedge clk_in) disable iff (srst_in)
		wr_coarse |=> coarse_reg[COARSE_MSB:COARSE_LSB]
		== $past(frame.data[COARSE_MSB:COARSE_LSB]))
		else $error("coarse field not taken from bits 9:6");

	a_fine_field: assert property (@(posedge clk_in) disable iff (srst_in)
		wr_fine && !cal_done |=> fine_reg[FINE_MSB:FINE_LSB]
		== $past(frame.data[FINE_MSB:FINE_LSB]))
		else $error("fine field not taken from bits 3:0");

	a_cal_start: assert property (@(posedge clk_in) disable iff (srst_in)
		start_ok && state == CAL_IDLE |=> cal_busy_out && state == CAL_ARM)
		else $error("calibration did not start");

	a_busy_span: assert property (@(posedge clk_in) disable iff (srst_in)
		cal_busy_out
		== (state != CAL_IDLE))
		else $error("busy flag wrong during calibration");

	a_busy_clear: assert property (@(posedge clk_in) disable iff (srst_in)
		cal_done |=> !cal_busy_out && state == CAL_IDLE)
		else $error("busy flag not cleared after calibration");

	a_auto_fine: assert property (@(posedge clk_in) disable iff (srst_in)
		cal_done |=> fine_reg[FINE_MSB:FINE_LSB] == cal_fine
		&& cal_fine == $past(fine_pick))
		else $error("calibration did not write fine trim");

	a_meas_ro: assert property (@(posedge clk_in) disable iff (srst_in)
		state == CAL_IDLE && !start_ok |=> $stable(measure))
		else $error("measurement changed outside calibration");

endmodule

/* rtl/fbtc_spi_port.sv */
// Serial register port: 32-bit frames, 24 data, 5 address, 3 chip bits.
// Assumes pins arrive unsynchronised; sampled here with two flip-flops.
`timescale 1ns/1ps
module fbtc_spi_port
	import fbtc_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	input  wire logic              spi_sen_n_in,
	input  wire logic              spi_sck_in,
	input  wire logic              spi_sdi_in,
	input  wire logic [DATA_W-1:0] read_word_in,
	output fbtc_frame_type         frame_out,
	output logic                   frame_valid_out,
	output logic                   sdo_out,
	output logic                   sdo_oe_n_out
);

	// ==========================================================
	// Pin synchronisers
	logic [2:0] pin_raw;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	assign pin_raw = {spi_sen_n_in, spi_sck_in, spi_sdi_in};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					// Enable pin resets to its idle high level
					pin_meta[g] <= (g == 2) ? 1'b1 : 1'b0;
					pin_sync[g] <= (g == 2) ? 1'b1 : 1'b0;
				end else begin
					pin_meta[g] <= pin_raw[g];
					pin_sync[g] <= pin_meta[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Frame shifter
	logic           sen_prev, next_sen_prev;
	logic           sck_prev, next_sck_prev;
	logic [31:0]    in_shift, next_in_shift;
	logic [5:0]     bit_cnt, next_bit_cnt;
	logic [23:0]    out_shift, next_out_shift;
	fbtc_frame_type next_frame;
	logic           next_valid;
	logic           next_oe_n;
	logic           sen_fall, sen_rise, sck_rise;

	always_comb begin
		sen_fall       = sen_prev & ~pin_sync[2];
		sen_rise       = ~sen_prev & pin_sync[2];
		sck_rise       = ~sck_prev & pin_sync[1];
		next_sen_prev  = pin_sync[2];
		next_sck_prev  = pin_sync[1];
		next_in_shift  = in_shift;
		next_bit_cnt   = bit_cnt;
		next_out_shift = out_shift;
		next_frame     = frame_out;
		next_valid     = 1'b0;
		next_oe_n      = pin_sync[2];
		if (sen_fall) begin
			next_bit_cnt   = 6'h00;
			next_out_shift = read_word_in;
		end else if (!pin_sync[2] && sck_rise) begin
			next_in_shift  = {in_shift[30:0], pin_sync[0]};
			next_out_shift = {out_shift[22:0], 1'b0};
			if (bit_cnt != FRAME_BITS) begin
				next_bit_cnt = bit_cnt + 6'h01;
			end
		end else if (sen_rise && bit_cnt == FRAME_BITS
				&& in_shift[2:0] == CHIP_ADDR) begin
			next_valid      = 1'b1;
			next_frame.addr = in_shift[7:3];
			next_frame.data = in_shift[31:8];
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sen_prev        <= 1'b1;
			sck_prev        <= 1'b0;
			in_shift        <= 32'h00000000;
			bit_cnt         <= 6'h00;
			out_shift       <= RST_WORD;
			frame_out       <= '0;
			frame_valid_out <= 1'b0;
			sdo_oe_n_out    <= 1'b1;
		end else begin
			sen_prev        <= next_sen_prev;
			sck_prev        <= next_sck_prev;
			in_shift        <= next_in_shift;
			bit_cnt         <= next_bit_cnt;
			out_shift       <= next_out_shift;
			frame_out       <= next_frame;
			frame_valid_out <= next_valid;
			sdo_oe_n_out    <= next_oe_n;
		end
	end

	assign sdo_out = out_shift[23];

endmodule
